// *** rtl/gyro_irq_pkg.sv ***
// constants for the angular-rate interrupt routing block
package gyro_irq_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PIN_A_MOTION_MAP = 8'h17;
  localparam logic [7:0] OFS_EVENT_PIN_MAP = 8'h18;
  localparam logic [7:0] OFS_PIN_B_MOTION_MAP = 8'h19;
  localparam logic [7:0] OFS_DETECTOR_SOURCE = 8'h1a;
  localparam logic [7:0] OFS_THRESHOLD_SOURCE = 8'h1b;
  localparam logic [7:0] OFS_DURATION_AXIS = 8'h1c;
  localparam logic [7:0] OFS_NEWDATA_ENABLE = 8'h15;
  localparam logic [7:0] OFS_LATCH_CTRL = 8'h21;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MAP = 8'h00;
  localparam logic [7:0] RST_SOURCE = 8'h00;
  localparam logic [7:0] RST_THRESHOLD = 8'h04;
  localparam logic [7:0] RST_DURATION = 8'ha0;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_MOTION_RATE = 3;
  localparam int BIT_MOTION_ANY = 1;
  localparam int BIT_A_NEWDATA = 0;
  localparam int BIT_A_QUICKCAL = 1;
  localparam int BIT_A_QUEUE = 2;
  localparam int BIT_A_AUTOCAL = 3;
  localparam int BIT_B_AUTOCAL = 4;
  localparam int BIT_B_QUEUE = 5;
  localparam int BIT_B_QUICKCAL = 6;
  localparam int BIT_B_NEWDATA = 7;
  localparam int BIT_SLOWCAL_RAW = 5;
  localparam int BIT_RATE_RAW = 3;
  localparam int BIT_MOTION_RAW = 1;
  localparam int BIT_QUICKCAL_RAW = 7;
  localparam int BIT_NEWDATA_EN = 7;
  localparam int BIT_LATCH_RELEASE = 7;
  // masks of writable bits, reserved bits read zero
  localparam logic [7:0] MASK_MOTION_MAP = 8'h0a;
  localparam logic [7:0] MASK_SOURCE = 8'h2a;
  localparam logic [7:0] MASK_DURATION = 8'hf7;
  localparam logic [7:0] MASK_ENABLE = 8'hc4;
  // ---------------------------------------------------------------
  // scaling
  // ---------------------------------------------------------------
  localparam int THRESH_STEP_SHIFT = 4;
  localparam int AWAKE_BASE = 8;
  localparam int MOTION_DUR_STEP = 4;
  // event index order on the shared event vector
  typedef enum logic [2:0] {
    EV_NEWDATA, EV_QUEUE, EV_QUICKCAL, EV_AUTOCAL, EV_RATE, EV_MOTION
  } event_idx_t;
  localparam int NUM_EVENTS = 6;
endpackage : gyro_irq_pkg

// *** rtl/gyro_cfg_if.sv ***
// configuration carrier between register file and routing logic
interface gyro_cfg_if;
  logic [gyro_irq_pkg::NUM_EVENTS-1:0] route_a;
  logic [gyro_irq_pkg::NUM_EVENTS-1:0] route_b;
  logic newdata_enable;
  modport regs (output route_a, output route_b, output newdata_enable);
  modport route (input route_a, input route_b, input newdata_enable);
endinterface : gyro_cfg_if

// *** rtl/gyro_pin_router.sv ***
// ors the mapped events onto the two interrupt pins
module gyro_pin_router (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // configuration
  gyro_cfg_if.route cfg,
  // events
  input wire logic [gyro_irq_pkg::NUM_EVENTS-1:0] events,
  // pins, active high before polarity
  output logic pin_a,
  output logic pin_b
);
  logic [gyro_irq_pkg::NUM_EVENTS-1:0] gated;
  logic pin_a_next;
  logic pin_b_next;
  logic pin_a_reg;
  logic pin_b_reg;

  // R21: newdata gate
  assign gated = {events[gyro_irq_pkg::NUM_EVENTS-1:1],
                  events[gyro_irq_pkg::EV_NEWDATA] & cfg.newdata_enable};
  // R23: or of mapped
  assign pin_a_next = |(gated & cfg.route_a);
  assign pin_b_next = |(gated & cfg.route_b);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_reg <= 1'b0;
      pin_b_reg <= 1'b0;
    end else begin
      pin_a_reg <= pin_a_next;
      pin_b_reg <= pin_b_next;
    end
  end

  assign pin_a = pin_a_reg;
  assign pin_b = pin_b_reg;
endmodule : gyro_pin_router

// *** rtl/gyro_motion_cfg.sv ***
// decodes the any-motion settings into working values
module gyro_motion_cfg (
  // fields
  input wire logic [7:0] threshold_reg,
  input wire logic [7:0] duration_reg,
  // decoded
  output logic [11:0] motion_threshold_lsb,
  output logic [6:0] awake_samples,
  output logic [4:0] motion_samples,
  output logic [2:0] axis_enable,
  output logic motion_enabled
);
  logic [7:0] th_plus;

  // R17: (field+1)*16
  assign th_plus = {1'b0, threshold_reg[6:0]} + 8'h01;
  // field 7f gives 2048, so the result needs twelve bits
  assign motion_threshold_lsb = {4'h0, th_plus} <<
                                gyro_irq_pkg::THRESH_STEP_SHIFT;
  // R18: 8,16,32,64
  assign awake_samples = 7'(gyro_irq_pkg::AWAKE_BASE) << duration_reg[7:6];
  // R19: 4,8,12,16
  assign motion_samples = 5'((duration_reg[5:4] + 3'h1)
                          * gyro_irq_pkg::MOTION_DUR_STEP);
  // R20: any axis enables
  assign axis_enable = duration_reg[2:0];
  assign motion_enabled = |duration_reg[2:0];
endmodule : gyro_motion_cfg

// *** rtl/gyro_irq_routing.sv ***
// register file and interrupt pin routing for the angular-rate part
// Behaviour
// R1: map0 bit3 routes high rate to pin a
// R2: map0 bit1 routes any-motion to pin a
// R3: map1 bit0 routes new data to pin a
// R4: map1 bit7 routes new data to pin b
// R5: map1 bit1 routes quick offset to pin a
// R6: map1 bit6 routes quick offset to pin b
// R7: map1 bit2 routes queue event to pin a
// R8: map1 bit5 routes queue event to pin b
// R9: map1 bit3 routes auto offset to pin a
// R10: map1 bit4 routes auto offset to pin b
// R11: map2 bit3 routes high rate to pin b
// R12: map2 bit1 routes any-motion to pin b
// R13: source bit5 picks raw for slow offset
// R14: source bit3 picks raw for high rate
// R15: source bit1 picks raw for any-motion
// R16: threshold bit7 picks raw for quick offset
// R17: threshold is (field plus one) times 16
// R18: awake duration 8,16,32,64 samples
// R19: motion duration 4,8,12,16 samples
// R20: any axis enable enables any-motion
// R21: new data enable gates new data event
// R22: host writes one to release latches
// R23: pin is or of mapped events
// R24: software writes zero to reserved bits
module gyro_irq_routing (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // events from the detectors, same clock
  input wire logic ev_newdata,
  input wire logic ev_queue,
  input wire logic ev_quickcal,
  input wire logic ev_autocal,
  input wire logic ev_rate,
  input wire logic ev_motion,
  // interrupt pins, active high
  output logic gyro_irq_pin_a,
  output logic gyro_irq_pin_b,
  // data source selects
  output logic slowcal_use_raw,
  output logic rate_use_raw,
  output logic motion_use_raw,
  output logic quickcal_use_raw,
  // any-motion settings
  output logic [6:0] motion_threshold,
  output logic [11:0] motion_threshold_lsb,
  output logic [6:0] awake_samples,
  output logic [4:0] motion_samples,
  output logic [2:0] axis_enable,
  output logic motion_enabled,
  // latch release pulse
  output logic latch_release
);
  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] map_a_reg;
  logic [7:0] map_ev_reg;
  logic [7:0] map_b_reg;
  logic [7:0] source_reg;
  logic [7:0] threshold_reg;
  logic [7:0] duration_reg;
  logic [7:0] enable_reg;
  logic release_reg;
  logic [7:0] rdata_reg;

  logic hit_map_a;
  logic hit_map_ev;
  logic hit_map_b;
  logic hit_source;
  logic hit_threshold;
  logic hit_duration;
  logic hit_enable;
  logic hit_latch;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign hit_map_a = hit(reg_addr, gyro_irq_pkg::OFS_PIN_A_MOTION_MAP);
  assign hit_map_ev = hit(reg_addr, gyro_irq_pkg::OFS_EVENT_PIN_MAP);
  assign hit_map_b = hit(reg_addr, gyro_irq_pkg::OFS_PIN_B_MOTION_MAP);
  assign hit_source = hit(reg_addr, gyro_irq_pkg::OFS_DETECTOR_SOURCE);
  assign hit_threshold = hit(reg_addr, gyro_irq_pkg::OFS_THRESHOLD_SOURCE);
  assign hit_duration = hit(reg_addr, gyro_irq_pkg::OFS_DURATION_AXIS);
  assign hit_enable = hit(reg_addr, gyro_irq_pkg::OFS_NEWDATA_ENABLE);
  assign hit_latch = hit(reg_addr, gyro_irq_pkg::OFS_LATCH_CTRL);

  // reserved bits are masked so they always read zero
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      map_a_reg <= gyro_irq_pkg::RST_MAP;
      map_ev_reg <= gyro_irq_pkg::RST_MAP;
      map_b_reg <= gyro_irq_pkg::RST_MAP;
      source_reg <= gyro_irq_pkg::RST_SOURCE;
      threshold_reg <= gyro_irq_pkg::RST_THRESHOLD;
      duration_reg <= gyro_irq_pkg::RST_DURATION;
      enable_reg <= gyro_irq_pkg::RST_ENABLE;
    end else if (reg_wr) begin
      if (hit_map_a)
        map_a_reg <= reg_wdata & gyro_irq_pkg::MASK_MOTION_MAP;
      if (hit_map_ev)
        map_ev_reg <= reg_wdata;
      if (hit_map_b)
        map_b_reg <= reg_wdata & gyro_irq_pkg::MASK_MOTION_MAP;
      if (hit_source)
        source_reg <= reg_wdata & gyro_irq_pkg::MASK_SOURCE;
      if (hit_threshold)
        threshold_reg <= reg_wdata;
      if (hit_duration)
        duration_reg <= reg_wdata & gyro_irq_pkg::MASK_DURATION;
      if (hit_enable)
        enable_reg <= reg_wdata & gyro_irq_pkg::MASK_ENABLE;
    end
  end

  // R22: release pulse
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg)
      release_reg <= 1'b0;
    else
      release_reg <= reg_wr & hit_latch
                     & reg_wdata[gyro_irq_pkg::BIT_LATCH_RELEASE];
  end
  assign latch_release = release_reg;

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  logic [7:0] rdata_next;

  assign rdata_next = hit_map_a ? map_a_reg :
                      hit_map_ev ? map_ev_reg :
                      hit_map_b ? map_b_reg :
                      hit_source ? source_reg :
                      hit_threshold ? threshold_reg :
                      hit_duration ? duration_reg :
                      hit_enable ? enable_reg : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg)
      rdata_reg <= 8'h00;
    else if (reg_rd)
      rdata_reg <= rdata_next;
  end
  assign reg_rdata = rdata_reg;

  // ---------------------------------------------------------------
  // routing configuration
  // ---------------------------------------------------------------
  gyro_cfg_if cfg ();
  logic [gyro_irq_pkg::NUM_EVENTS-1:0] events;

  assign events = {ev_motion, ev_rate, ev_autocal, ev_quickcal, ev_queue,
                   ev_newdata};
  // R3: newdata a
  assign cfg.route_a[gyro_irq_pkg::EV_NEWDATA] =
    map_ev_reg[gyro_irq_pkg::BIT_A_NEWDATA];
  // R7: queue a
  assign cfg.route_a[gyro_irq_pkg::EV_QUEUE] =
    map_ev_reg[gyro_irq_pkg::BIT_A_QUEUE];
  // R5: quickcal a
  assign cfg.route_a[gyro_irq_pkg::EV_QUICKCAL] =
    map_ev_reg[gyro_irq_pkg::BIT_A_QUICKCAL];
  // R9: autocal a
  assign cfg.route_a[gyro_irq_pkg::EV_AUTOCAL] =
    map_ev_reg[gyro_irq_pkg::BIT_A_AUTOCAL];
  // R1: rate a
  assign cfg.route_a[gyro_irq_pkg::EV_RATE] =
    map_a_reg[gyro_irq_pkg::BIT_MOTION_RATE];
  // R2: motion a
  assign cfg.route_a[gyro_irq_pkg::EV_MOTION] =
    map_a_reg[gyro_irq_pkg::BIT_MOTION_ANY];
  // R4: newdata b
  assign cfg.route_b[gyro_irq_pkg::EV_NEWDATA] =
    map_ev_reg[gyro_irq_pkg::BIT_B_NEWDATA];
  // R8: queue b
  assign cfg.route_b[gyro_irq_pkg::EV_QUEUE] =
    map_ev_reg[gyro_irq_pkg::BIT_B_QUEUE];
  // R6: quickcal b
  assign cfg.route_b[gyro_irq_pkg::EV_QUICKCAL] =
    map_ev_reg[gyro_irq_pkg::BIT_B_QUICKCAL];
  // R10: autocal b
  assign cfg.route_b[gyro_irq_pkg::EV_AUTOCAL] =
    map_ev_reg[gyro_irq_pkg::BIT_B_AUTOCAL];
  // R11: rate b
  assign cfg.route_b[gyro_irq_pkg::EV_RATE] =
    map_b_reg[gyro_irq_pkg::BIT_MOTION_RATE];
  // R12: motion b
  assign cfg.route_b[gyro_irq_pkg::EV_MOTION] =
    map_b_reg[gyro_irq_pkg::BIT_MOTION_ANY];
  // R21: newdata enable
  assign cfg.newdata_enable = enable_reg[gyro_irq_pkg::BIT_NEWDATA_EN];

  // the pins are registered so glitches of the or never reach the host
  gyro_pin_router u_router (
    .clk_sys(clk_sys),
    .rst_n(rst_n_reg),
    .cfg(cfg.route),
    .events(events),
    .pin_a(gyro_irq_pin_a),
    .pin_b(gyro_irq_pin_b)
  );

  // ---------------------------------------------------------------
  // source selects and motion settings
  // ---------------------------------------------------------------
  // R13: slow offset source
  assign slowcal_use_raw = source_reg[gyro_irq_pkg::BIT_SLOWCAL_RAW];
  // R14: high rate source
  assign rate_use_raw = source_reg[gyro_irq_pkg::BIT_RATE_RAW];
  // R15: motion source
  assign motion_use_raw = source_reg[gyro_irq_pkg::BIT_MOTION_RAW];
  // R16: quick offset source
  assign quickcal_use_raw = threshold_reg[gyro_irq_pkg::BIT_QUICKCAL_RAW];
  assign motion_threshold = threshold_reg[6:0];

  gyro_motion_cfg u_motion (
    .threshold_reg(threshold_reg),
    .duration_reg(duration_reg),
    .motion_threshold_lsb(motion_threshold_lsb),
    .awake_samples(awake_samples),
    .motion_samples(motion_samples),
    .axis_enable(axis_enable),
    .motion_enabled(motion_enabled)
  );
endmodule : gyro_irq_routing

// *** tb/gyro_irq_routing_properties.sv ***
// port assertions for the gyro interrupt routing block
module gyro_irq_routing_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // events and pins
  input wire logic ev_newdata,
  input wire logic ev_queue,
  input wire logic ev_quickcal,
  input wire logic ev_autocal,
  input wire logic ev_rate,
  input wire logic ev_motion,
  input wire logic gyro_irq_pin_a,
  input wire logic gyro_irq_pin_b,
  // settings
  input wire logic slowcal_use_raw,
  input wire logic rate_use_raw,
  input wire logic motion_use_raw,
  input wire logic quickcal_use_raw,
  input wire logic [6:0] motion_threshold,
  input wire logic [11:0] motion_threshold_lsb,
  input wire logic [6:0] awake_samples,
  input wire logic [4:0] motion_samples,
  input wire logic [2:0] axis_enable,
  input wire logic motion_enabled,
  input wire logic latch_release
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  // ---------------------------------------------------------------
  // shadow of the maps
  // ---------------------------------------------------------------
  logic [7:0] m17_reg, m18_reg, m19_reg, en_reg, wd_reg;
  logic [1:0] up_reg;
  logic ready, hit_a, hit_b;
  // AST_PIN_A and AST_PIN_B judge the pins only once the reset synchroniser has let go
  assign ready = (up_reg == 2'h3);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {m17_reg, m18_reg, m19_reg, en_reg, wd_reg, up_reg} <= '0;
    end else begin
      up_reg <= ready ? up_reg : up_reg + 2'h1;
      wd_reg <= reg_wdata;
      if (reg_wr && reg_addr == 8'h17) m17_reg <= reg_wdata;
      if (reg_wr && reg_addr == 8'h18) m18_reg <= reg_wdata;
      if (reg_wr && reg_addr == 8'h19) m19_reg <= reg_wdata;
      if (reg_wr && reg_addr == 8'h15) en_reg <= reg_wdata;
    end
  end
  assign hit_a = (m17_reg[3] & ev_rate) | (m17_reg[1] & ev_motion)
    | (m18_reg[0] & en_reg[7] & ev_newdata) | (m18_reg[1] & ev_quickcal)
    | (m18_reg[2] & ev_queue) | (m18_reg[3] & ev_autocal);
  assign hit_b = (m19_reg[3] & ev_rate) | (m19_reg[1] & ev_motion)
    | (m18_reg[7] & en_reg[7] & ev_newdata) | (m18_reg[6] & ev_quickcal)
    | (m18_reg[5] & ev_queue) | (m18_reg[4] & ev_autocal);
  AST_RATE_A: assert property (reg_wr && reg_addr == 8'h17 && reg_wdata[3] ##1 ev_rate |=> gyro_irq_pin_a)
    else $error("rate event not on pin a");
  AST_PIN_A: assert property (ready |-> gyro_irq_pin_a == $past(hit_a))
    else $error("pin a differs from mapped events");
  AST_PIN_B: assert property (ready |-> gyro_irq_pin_b == $past(hit_b))
    else $error("pin b differs from mapped events");
  AST_SRC: assert property (reg_wr && reg_addr == 8'h1a |=> {slowcal_use_raw, rate_use_raw, motion_use_raw} == {wd_reg[5], wd_reg[3], wd_reg[1]})
    else $error("source selects wrong");
  AST_QUICK: assert property (reg_wr && reg_addr == 8'h1b |=> quickcal_use_raw == wd_reg[7] && motion_threshold == wd_reg[6:0])
    else $error("quick source or field wrong");
  AST_THRESH: assert property (motion_threshold_lsb == ({5'h00, motion_threshold} + 12'h001) << 4)
    else $error("threshold scale wrong");
  AST_DUR: assert property (reg_wr && reg_addr == 8'h1c |=> awake_samples == (7'h08 << wd_reg[7:6]) && motion_samples == {1'b0, wd_reg[5:4], 2'h0} + 5'h04 && axis_enable == wd_reg[2:0])
    else $error("duration decode wrong");
  AST_AXIS: assert property (motion_enabled == (axis_enable != 3'h0))
    else $error("motion enable wrong");
  AST_RELEASE: assert property (reg_wr && reg_addr == 8'h21 && reg_wdata[7] |=> latch_release ##1 !latch_release)
    else $error("release pulse wrong");
endmodule : gyro_irq_routing_properties

// *** tb/gyro_host_model.sv ***
// host model driving the register port
module gyro_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  end
  function automatic logic [7:0] keep(input logic [7:0] a);
    case (a)
      8'h17, 8'h19: keep = gyro_irq_pkg::MASK_MOTION_MAP;
      8'h1a: keep = gyro_irq_pkg::MASK_SOURCE;
      8'h1c: keep = gyro_irq_pkg::MASK_DURATION;
      8'h15: keep = gyro_irq_pkg::MASK_ENABLE;
      default: keep = 8'hff;
    endcase
  endfunction : keep
  // idle bus shows the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d & keep(a)};
    @(posedge clk_sys);
    @(negedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} = {1'b0, ~reg_addr, ~reg_wdata};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk_sys);
    @(negedge clk_sys);
    {reg_rd, reg_addr} = {1'b0, ~a};
    d = reg_rdata;
  endtask : rd
  task automatic release_latches();
    wr(8'h21, 8'h80);
  endtask : release_latches
endmodule : gyro_host_model

// *** tb/testbench.sv ***
// bench top: clock, reset, scenarios and verdict
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] ev = 6'h00;
  logic reg_wr, reg_rd, gyro_irq_pin_a, gyro_irq_pin_b, latch_release;
  logic slowcal_use_raw, rate_use_raw, motion_use_raw, quickcal_use_raw;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_seen;
  logic [6:0] motion_threshold, awake_samples;
  logic [11:0] motion_threshold_lsb;
  logic [4:0] motion_samples;
  logic [2:0] axis_enable;
  logic motion_enabled;
  int bad_count = 0;
  int tests_run = 0;
  always #50 clk_sys = ~clk_sys;
  gyro_host_model i_gyro_host_model (.clk_sys, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata);
  gyro_irq_routing i_gyro_irq_routing (.clk_sys, .arst_n, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .ev_newdata(ev[0]), .ev_queue(ev[1]),
    .ev_quickcal(ev[2]), .ev_autocal(ev[3]), .ev_rate(ev[4]),
    .ev_motion(ev[5]), .gyro_irq_pin_a, .gyro_irq_pin_b, .slowcal_use_raw,
    .rate_use_raw, .motion_use_raw, .quickcal_use_raw, .motion_threshold,
    .motion_threshold_lsb, .awake_samples, .motion_samples, .axis_enable,
    .motion_enabled, .latch_release);
  task automatic check(input string n, input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic tick();
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_gyro_host_model.wr(a, d);
  endtask : wr
  task automatic route(input logic [7:0] a, input int b, input int i, input logic on_b);
    wr(8'h15, 8'h80);
    ev = 6'h01 << i;
    wr(a, 8'h00);
    tick();
    check("off", 12'h000, {10'h0, gyro_irq_pin_a, gyro_irq_pin_b});
    wr(a, 8'h01 << b);
    tick();
    check("on", {10'h0, !on_b, on_b}, {10'h0, gyro_irq_pin_a, gyro_irq_pin_b});
    ev = 6'h00;
    wr(a, 8'h00);
  endtask : route
  task automatic t_or();
    wr(8'h17, 8'h0a);
    wr(8'h18, 8'h0f);
    ev = 6'h06;
    tick();
    check("or two", 12'h001, {11'h0, gyro_irq_pin_a});
    ev = 6'h04;
    tick();
    check("or one", 12'h001, {11'h0, gyro_irq_pin_a});
    wr(8'h15, 8'h00);
    ev = 6'h01;
    tick();
    check("gated", 12'h000, {11'h0, gyro_irq_pin_a});
    wr(8'h15, 8'h80);
    tick();
    check("ungated", 12'h001, {11'h0, gyro_irq_pin_a});
    ev = 6'h00;
  endtask : t_or
  task automatic t_src();
    check("thr rst", 12'h050, motion_threshold_lsb);
    wr(8'h1a, 8'h2a);
    check("raw", 12'h007, {9'h0, slowcal_use_raw, rate_use_raw, motion_use_raw});
    wr(8'h1a, 8'h08);
    check("rate", 12'h002, {9'h0, slowcal_use_raw, rate_use_raw, motion_use_raw});
    wr(8'h1b, 8'h80);
    check("quick raw", 12'h001, {11'h0, quickcal_use_raw});
    check("thr min", 12'h010, motion_threshold_lsb);
    wr(8'h1b, 8'h7f);
    check("thr max", 12'h800, motion_threshold_lsb);
    check("thr fld", 12'h07f, {5'h0, motion_threshold});
    check("quick flt", 12'h000, {11'h0, quickcal_use_raw});
  endtask : t_src
  task automatic t_dur();
    logic [2:0] ax;
    check("aw rst", 12'h020, {5'h0, awake_samples});
    for (int c = 0; c < 4; c++) begin
      ax = (c == 3) ? 3'h0 : 3'h1 << c;
      wr(8'h1c, {c[1:0], c[1:0], 1'b0, ax});
      check("awake", 12'h008 << c, {5'h0, awake_samples});
      check("msamp", 12'(4 * (c + 1)), {7'h0, motion_samples});
      check("axes", {8'h0, ax != 3'h0, ax}, {8'h0, motion_enabled, axis_enable});
      i_gyro_host_model.rd(8'h1c, rd_seen);
      check("dur rd", {4'h0, c[1:0], c[1:0], 1'b0, ax}, {4'h0, rd_seen});
    end
  endtask : t_dur
  task automatic t_rel();
    i_gyro_host_model.release_latches();
    check("pulse", 12'h001, {11'h0, latch_release});
    tick();
    check("pulse end", 12'h000, {11'h0, latch_release});
    wr(8'h21, 8'h00);
    check("no pulse", 12'h000, {11'h0, latch_release});
    i_gyro_host_model.rd(8'h21, rd_seen);
    check("rel rd", 12'h000, {4'h0, rd_seen});
  endtask : t_rel
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) tick();
    t_src();
    t_dur();
    route(8'h17, 3, 4, 1'b0);
    route(8'h17, 1, 5, 1'b0);
    route(8'h18, 0, 0, 1'b0);
    route(8'h18, 7, 0, 1'b1);
    route(8'h18, 1, 2, 1'b0);
    route(8'h18, 6, 2, 1'b1);
    route(8'h18, 2, 1, 1'b0);
    route(8'h18, 5, 1, 1'b1);
    route(8'h18, 3, 3, 1'b0);
    route(8'h18, 4, 3, 1'b1);
    route(8'h19, 3, 4, 1'b1);
    route(8'h19, 1, 5, 1'b1);
    t_or();
    t_rel();
    final_report();
  end
  // scenarios need under two thousand cycles
  initial begin
    #2000000;
    bad_count++;
    final_report();
  end
endmodule : testbench
bind gyro_irq_routing gyro_irq_routing_properties i_gyro_irq_routing_properties (
  .clk_sys, .arst_n, .reg_wr, .reg_addr, .reg_wdata, .ev_newdata, .ev_queue,
  .ev_quickcal, .ev_autocal, .ev_rate, .ev_motion, .gyro_irq_pin_a,
  .gyro_irq_pin_b, .slowcal_use_raw, .rate_use_raw, .motion_use_raw,
  .quickcal_use_raw, .motion_threshold, .motion_threshold_lsb, .awake_samples,
  .motion_samples, .axis_enable, .motion_enabled, .latch_release);
